// ---- src/jrp_defines.vh ----
// Constants for the test-port reset, mode latch and identification block.
`ifndef JRP_DEFINES_VH
`define JRP_DEFINES_VH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define JRP_ADDR_W          32
`define JRP_CHIP_ID_ADDR    32'h01c40028
`define JRP_MODE_ADDR       32'h01c4002c
`define JRP_RDATA_ZERO      32'h00000000

// -----------------------------------------------------------------------------
// Identification layout
// -----------------------------------------------------------------------------
`define JRP_REV_MSB         31
`define JRP_REV_LSB         28
`define JRP_PART_MSB        27
`define JRP_PART_LSB        0
// Arbitrary neutral values, not those of any real part.
`define JRP_REV_DEFAULT     4'h1
`define JRP_PART_DEFAULT    28'h5a5a001
`define JRP_PART_RESET      28'h0000001

// -----------------------------------------------------------------------------
// Tap states (four-bit binary) and instructions
// -----------------------------------------------------------------------------
`define JRP_TLR             4'h0
`define JRP_RTI             4'h1
`define JRP_SEL_DR          4'h2
`define JRP_CAP_DR          4'h3
`define JRP_SH_DR           4'h4
`define JRP_EX1_DR          4'h5
`define JRP_PA_DR           4'h6
`define JRP_EX2_DR          4'h7
`define JRP_UP_DR           4'h8
`define JRP_SEL_IR          4'h9
`define JRP_CAP_IR          4'ha
`define JRP_SH_IR           4'hb
`define JRP_EX1_IR          4'hc
`define JRP_PA_IR           4'hd
`define JRP_EX2_IR          4'he
`define JRP_UP_IR           4'hf

`define JRP_IR_W            4
`define JRP_IR_IDCODE       4'h1
`define JRP_IR_BYPASS       4'hf
`define JRP_IR_CAPTURE      4'h1
`define JRP_MODE_BSCAN      2'h0

`endif

// ---- src/jrp_top.v ----
// Test access port with reset handling, mode-select latch and identification register.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "jrp_defines.vh"

module jrp_top (
    input  wire        pclk,                 // Bus clock, 25 MHz.
    input  wire        presetn,              // Asynchronous reset, active low.
    input  wire        sys_rst_n,            // Device system reset, active low.
    input  wire [3:0]  silicon_rev,          // Revision strap.
    input  wire        psel,                 // APB select.
    input  wire        penable,              // APB enable.
    input  wire        pwrite,               // APB direction.
    input  wire [31:0] paddr,                // APB byte address.
    input  wire [31:0] pwdata,               // APB write data, ignored.
    output reg  [31:0] prdata,               // APB read data.
    output reg         pready,               // APB ready.
    output reg         pslverr,              // APB error.
    input  wire        tck,                  // Test clock pin.
    input  wire        tms,                  // Test mode select pin.
    input  wire        tdi,                  // Test data in pin.
    input  wire        trst_n,               // Test reset pin, low asserted.
    input  wire        trst_n_driven,        // High while the pin is driven at all.
    input  wire [1:0]  debug_mode_select_pins, // Debug mode-select pins.
    output reg         tdo,                  // Test data out.
    output reg         tdo_oe,               // Test data out enable.
    output reg         tap_in_reset,         // Tap and emulation logic held in reset.
    output reg  [1:0]  debug_mode_reg,       // Latched mode pins.
    output reg         emulation_mode        // High for emulation, low for scan.
);

// -----------------------------------------------------------------------------
// Synchronisers
// -----------------------------------------------------------------------------
    // An undriven pin reads as asserted, as an internal pull-down would give.
    wire trst_pin_n = trst_n_driven & trst_n;

    reg [2:0] tck_s_reg;
    reg [1:0] tms_s_reg;
    reg [1:0] tdi_s_reg;
    reg [1:0] trst_s_reg;
    reg [1:0] srst_s_reg;
    reg [1:0] mode_a_reg;
    reg [1:0] mode_b_reg;
    reg [3:0] rev_a_reg;
    reg [3:0] rev_b_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // The link clock idles high; starting high avoids a false rise after reset.
            tck_s_reg  <= 3'h7;
            tms_s_reg  <= 2'h3;
            tdi_s_reg  <= 2'h3;
            trst_s_reg <= 2'h0;
            srst_s_reg <= 2'h0;
            mode_a_reg <= 2'h0;
            mode_b_reg <= 2'h0;
            rev_a_reg  <= 4'h0;
            rev_b_reg  <= 4'h0;
        end else begin
            tck_s_reg  <= {tck_s_reg[1:0], tck};
            tms_s_reg  <= {tms_s_reg[0], tms};
            tdi_s_reg  <= {tdi_s_reg[0], tdi};
            trst_s_reg <= {trst_s_reg[0], trst_pin_n};
            srst_s_reg <= {srst_s_reg[0], sys_rst_n};
            mode_a_reg <= debug_mode_select_pins;
            mode_b_reg <= mode_a_reg;
            rev_a_reg  <= silicon_rev;
            rev_b_reg  <= rev_a_reg;
        end
    end

    wire tck_rise = tck_s_reg[1] & ~tck_s_reg[2];
    wire tck_fall = ~tck_s_reg[1] & tck_s_reg[2];
    wire tms_v    = tms_s_reg[1];
    wire tdi_v    = tdi_s_reg[1];
    wire trst_v_n = trst_s_reg[1];
    wire sys_up   = srst_s_reg[1];

// -----------------------------------------------------------------------------
// Test reset sampled on test clock, and mode latch
// -----------------------------------------------------------------------------
    reg       trst_tck_n_reg;
    reg       latch_armed_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [`JRP_IR_W-1:0] ir_reg;
    reg [`JRP_IR_W-1:0] ir_sh_reg;
    reg [31:0] dr_sh_reg;
    reg [31:0] id_live;

    // Clock-to-clock sampling of the test reset means a reset with no test clock
    // running is not seen; the system must keep the test clock going.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trst_tck_n_reg  <= 1'b0;
            latch_armed_reg <= 1'b0;
            debug_mode_reg  <= `JRP_MODE_BSCAN;
            emulation_mode  <= 1'b0;
            tap_in_reset    <= 1'b1;
        end else begin
            if (tck_rise) begin
                trst_tck_n_reg <= trst_v_n;
            end
            tap_in_reset <= ~trst_tck_n_reg;
            // Arm only while system is out of reset and test reset is asserted.
            if (!sys_up) begin
                latch_armed_reg <= 1'b0;
            end else if (!trst_tck_n_reg) begin
                latch_armed_reg <= 1'b1;
            end
            if (tck_rise && sys_up && latch_armed_reg && !trst_tck_n_reg && trst_v_n) begin
                debug_mode_reg  <= mode_b_reg;
                emulation_mode  <= (mode_b_reg != `JRP_MODE_BSCAN);
                latch_armed_reg <= 1'b0;
            end
        end
    end

// -----------------------------------------------------------------------------
// Identification value
// -----------------------------------------------------------------------------
    // The part field is only trusted once the system reset is gone.
    always @* begin
        id_live = {rev_b_reg, `JRP_PART_DEFAULT};
        if (!sys_up) begin
            id_live[`JRP_PART_MSB:`JRP_PART_LSB] = `JRP_PART_RESET;
        end
    end

    // Decides whether the data path carries the identification word or the bypass bit.
    function is_idcode;
        input [`JRP_IR_W-1:0] ir;
        begin
            is_idcode = (ir == `JRP_IR_IDCODE);
        end
    endfunction

// -----------------------------------------------------------------------------
// Tap state machine
// -----------------------------------------------------------------------------
    always @* begin
        case (state_reg)
            `JRP_TLR:    state_next = tms_v ? `JRP_TLR    : `JRP_RTI;
            `JRP_RTI:    state_next = tms_v ? `JRP_SEL_DR : `JRP_RTI;
            `JRP_SEL_DR: state_next = tms_v ? `JRP_SEL_IR : `JRP_CAP_DR;
            `JRP_CAP_DR: state_next = tms_v ? `JRP_EX1_DR : `JRP_SH_DR;
            `JRP_SH_DR:  state_next = tms_v ? `JRP_EX1_DR : `JRP_SH_DR;
            `JRP_EX1_DR: state_next = tms_v ? `JRP_UP_DR  : `JRP_PA_DR;
            `JRP_PA_DR:  state_next = tms_v ? `JRP_EX2_DR : `JRP_PA_DR;
            `JRP_EX2_DR: state_next = tms_v ? `JRP_UP_DR  : `JRP_SH_DR;
            `JRP_UP_DR:  state_next = tms_v ? `JRP_SEL_DR : `JRP_RTI;
            `JRP_SEL_IR: state_next = tms_v ? `JRP_TLR    : `JRP_CAP_IR;
            `JRP_CAP_IR: state_next = tms_v ? `JRP_EX1_IR : `JRP_SH_IR;
            `JRP_SH_IR:  state_next = tms_v ? `JRP_EX1_IR : `JRP_SH_IR;
            `JRP_EX1_IR: state_next = tms_v ? `JRP_UP_IR  : `JRP_PA_IR;
            `JRP_PA_IR:  state_next = tms_v ? `JRP_EX2_IR : `JRP_PA_IR;
            `JRP_EX2_IR: state_next = tms_v ? `JRP_UP_IR  : `JRP_SH_IR;
            `JRP_UP_IR:  state_next = tms_v ? `JRP_SEL_DR : `JRP_RTI;
            default:     state_next = `JRP_TLR;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= `JRP_TLR;
            ir_reg    <= `JRP_IR_IDCODE;
            ir_sh_reg <= `JRP_IR_CAPTURE;
            dr_sh_reg <= `JRP_RDATA_ZERO;
            tdo       <= 1'b0;
            tdo_oe    <= 1'b0;
        end else if (!trst_tck_n_reg) begin
            state_reg <= `JRP_TLR;
            ir_reg    <= `JRP_IR_IDCODE;
            tdo_oe    <= 1'b0;
        end else if (tck_rise) begin
            state_reg <= state_next;
            case (state_reg)
                `JRP_TLR:    ir_reg    <= `JRP_IR_IDCODE;
                `JRP_CAP_IR: ir_sh_reg <= `JRP_IR_CAPTURE;
                `JRP_SH_IR:  ir_sh_reg <= {tdi_v, ir_sh_reg[`JRP_IR_W-1:1]};
                `JRP_UP_IR:  ir_reg    <= ir_sh_reg;
                `JRP_CAP_DR: dr_sh_reg <= is_idcode(ir_reg) ? id_live
                                                                      : `JRP_RDATA_ZERO;
                `JRP_SH_DR: begin
                    if (is_idcode(ir_reg)) begin
                        dr_sh_reg <= {tdi_v, dr_sh_reg[31:1]};
                    end else begin
                        dr_sh_reg <= {31'h00000000, tdi_v};
                    end
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            tdo_oe <= (state_reg == `JRP_SH_DR) || (state_reg == `JRP_SH_IR);
            tdo    <= (state_reg == `JRP_SH_IR) ? ir_sh_reg[0] : dr_sh_reg[0];
        end
    end

// -----------------------------------------------------------------------------
// APB slave
// -----------------------------------------------------------------------------
    // One wait-free access: answers in the first access cycle. Writes are errors.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `JRP_RDATA_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= `JRP_RDATA_ZERO;
            if (psel && !penable) begin
                if (pwrite) begin
                    pslverr <= 1'b1;
                end else if (paddr == `JRP_CHIP_ID_ADDR) begin
                    prdata <= id_live;
                end else if (paddr == `JRP_MODE_ADDR) begin
                    prdata <= {28'h0000000, tap_in_reset, emulation_mode, debug_mode_reg};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule

// ---- test/jrp_jtag_ctl.sv ----
// Model of the outside test controller driving the test-port pins.
`timescale 1ns/1ps
module jrp_jtag_ctl (
    input  wire pclk,          // Clock pacing the pins.
    input  wire tdo,           // Test data out.
    output reg  tck,           // Test clock.
    output reg  tms,           // Mode select.
    output reg  tdi,           // Data in.
    output reg  trst_n,        // Test reset.
    output reg  trst_n_driven  // Reset pin driven.
);
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b0;
        trst_n_driven = 1'b1;
    end
    task pin(input logic drv, input logic v);
        begin
            trst_n_driven <= drv;
            // A released pin is left high, so only the driven flag can reset the port.
            trst_n <= drv ? v : 1'b1;
        end
    endtask
    // Eight bus clocks a cycle give the 320 ns link clock; it idles high.
    task cyc(input logic m, input logic d, output logic o);
        begin
            tck <= 1'b0;
            tms <= m;
            tdi <= d;
            repeat (4) @(posedge pclk);
            o = tdo;
            tck <= 1'b1;
            repeat (4) @(posedge pclk);
        end
    endtask
endmodule

// ---- test/jrp_top_sva.sv ----
// Assertions on the ports of the test-port block.
`timescale 1ns/1ps
`include "jrp_defines.vh"
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module jrp_top_sva (
    input wire        pclk,           // Clock.
    input wire        presetn,        // Reset.
    input wire        sys_rst_n,      // System reset.
    input wire [3:0]  silicon_rev,    // Revision.
    input wire        psel,           // Select.
    input wire        penable,        // Enable.
    input wire        pwrite,         // Direction.
    input wire [31:0] paddr,          // Address.
    input wire [31:0] prdata,         // Read data.
    input wire        pready,         // Ready.
    input wire        pslverr,        // Error.
    input wire        trst_n,         // Test reset pin.
    input wire        trst_n_driven,  // Pin driven.
    input wire        tdo_oe,         // Data out enable.
    input wire        tap_in_reset,   // Port held in reset.
    input wire [1:0]  debug_mode_reg, // Latched mode.
    input wire        emulation_mode  // Emulation selected.
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_id  = pready && !pwrite && paddr == `JRP_CHIP_ID_ADDR;
    wire mapped = paddr == `JRP_CHIP_ID_ADDR || paddr == `JRP_MODE_ADDR;
    AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    AST_ONE_PULSE: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    AST_RO_WRITE: assert property (pready && pwrite |-> pslverr)
        else $error("write accepted");
    AST_UNMAPPED: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access answered");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    AST_REV: assert property (rd_id |-> prdata[31:28] == silicon_rev && !pslverr)
        else $error("revision digit wrong");
    AST_VARIANT: assert property (rd_id && sys_rst_n == $past(sys_rst_n, 6) |->
        prdata[27:0] == (sys_rst_n ? `JRP_PART_DEFAULT : `JRP_PART_RESET))
        else $error("identity variant wrong");
    AST_HELD_RESET: assert property (tap_in_reset && (!trst_n || !trst_n_driven)
        |=> tap_in_reset) else $error("port left reset while pin asserted");
    AST_NO_OE: assert property (tap_in_reset |-> !tdo_oe)
        else $error("data out driven in reset");
    AST_MODE_HOLD: assert property (!trst_n && !$past(trst_n, 8) |-> $stable(debug_mode_reg))
        else $error("mode changed without reset rise");
    AST_EMU: assert property ($stable(debug_mode_reg) |->
        emulation_mode == (debug_mode_reg != `JRP_MODE_BSCAN)) else $error("mode decode wrong");
endmodule

bind jrp_top jrp_top_sva chk (.pclk, .presetn, .sys_rst_n, .silicon_rev, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .trst_n, .trst_n_driven, .tdo_oe,
    .tap_in_reset, .debug_mode_reg, .emulation_mode);

// ---- test/jrp_top_test.sv ----
// Self-checking bench for the test-port block.
`timescale 1ns/1ps
`include "jrp_defines.vh"
module jrp_top_test;
    typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic e;} jrp_row_t;
    logic pclk = 1'b0, presetn = 1'b0, sys_rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, b;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, d, seen;
    logic [1:0] mode_pins = 2'h2;
    logic [15:0] cycles = 16'h0;
    int n_errors = 0, n_tests = 0, i;
    wire [31:0] prdata;
    wire [1:0] debug_mode_reg;
    wire pready, pslverr, tck, tms, tdi, trst_n, trst_n_driven, tdo, tdo_oe, tap_in_reset, emu;
    wire [31:0] id_exp = {4'h3, `JRP_PART_DEFAULT};
    jrp_row_t rows [6] = '{
        '{1'b0, `JRP_CHIP_ID_ADDR, {4'h3, `JRP_PART_DEFAULT}, 1'b0},
        '{1'b0, `JRP_CHIP_ID_ADDR, {4'h3, `JRP_PART_DEFAULT}, 1'b0},
        '{1'b1, `JRP_CHIP_ID_ADDR, 32'h0, 1'b1}, '{1'b1, `JRP_MODE_ADDR, 32'h0, 1'b1},
        '{1'b0, 32'h01c40030, 32'h0, 1'b1}, '{1'b0, `JRP_MODE_ADDR, 32'h8, 1'b0}};
    jrp_top dut (.pclk(pclk), .presetn(presetn), .sys_rst_n(sys_rst_n), .silicon_rev(4'h3),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .trst_n_driven(trst_n_driven), .debug_mode_select_pins(mode_pins),
        .tdo(tdo), .tdo_oe(tdo_oe), .tap_in_reset(tap_in_reset),
        .debug_mode_reg(debug_mode_reg), .emulation_mode(emu));
    jrp_jtag_ctl ctl (.pclk(pclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .trst_n_driven(trst_n_driven));
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 16'h1;
        if (cycles == 16'h1800) begin
            n_errors++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, output logic [31:0] rd, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'hffffffff;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task trst(input logic drv, input logic v);
        ctl.pin(drv, v);
        @(posedge pclk);
        ctl.cyc(1'b1, 1'b0, b);
        ctl.cyc(1'b1, 1'b0, b);
        repeat (6) @(posedge pclk);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(posedge pclk);
        chk("reset hold", 32'(tap_in_reset), 32'h1);
        chk("mode reset", 32'(debug_mode_reg), 32'h0);
        apb(1'b0, `JRP_CHIP_ID_ADDR, d, b);
        chk("variant in reset", d, {4'h3, `JRP_PART_RESET});
        trst(1'b1, 1'b1);
        chk("no latch in reset", 32'(debug_mode_reg), 32'h0);
        trst(1'b1, 1'b0);
        sys_rst_n <= 1'b1;
        repeat (8) @(posedge pclk);
        for (i = 0; i < 6; i++) begin
            apb(rows[i].w, rows[i].a, d, b);
            chk("read data", d, rows[i].d);
            chk("error", 32'(b), 32'(rows[i].e));
        end
        trst(1'b0, 1'b1);
        chk("undriven reset", 32'(tap_in_reset), 32'h1);
        trst(1'b1, 1'b1);
        chk("mode latch", 32'(debug_mode_reg), 32'h2);
        chk("emulation", 32'(emu), 32'h1);
        mode_pins <= 2'h1;
        repeat (8) @(posedge pclk);
        apb(1'b0, `JRP_MODE_ADDR, d, b);
        chk("mode word", d, 32'h6);
        ctl.cyc(1'b0, 1'b0, b);
        ctl.cyc(1'b1, 1'b0, b);
        ctl.cyc(1'b0, 1'b0, b);
        ctl.cyc(1'b0, 1'b0, b);
        for (i = 0; i < 32; i++) begin
            ctl.cyc(i == 31, 1'b0, seen[i]);
            if (i == 1) chk("data out enable", 32'(tdo_oe), 32'h1);
        end
        chk("scanned id", seen, id_exp);
        repeat (5) ctl.cyc(1'b1, 1'b0, b);
        // Bypass path with the system held in reset: the tap must not care.
        sys_rst_n <= 1'b0;
        ctl.cyc(1'b0, 1'b0, b);
        ctl.cyc(1'b1, 1'b0, b);
        ctl.cyc(1'b1, 1'b0, b);
        ctl.cyc(1'b0, 1'b0, b);
        ctl.cyc(1'b0, 1'b0, b);
        // Four ones load the bypass instruction while the capture word comes out.
        for (i = 0; i < 4; i++) ctl.cyc(i == 3, 1'b1, seen[i]);
        chk("ir capture", 32'(seen[3:0]), 32'(`JRP_IR_CAPTURE));
        ctl.cyc(1'b1, 1'b0, b);
        ctl.cyc(1'b0, 1'b0, b);
        ctl.cyc(1'b1, 1'b0, b);
        ctl.cyc(1'b0, 1'b0, b);
        ctl.cyc(1'b0, 1'b0, b);
        ctl.cyc(1'b0, 1'b1, seen[0]);
        ctl.cyc(1'b0, 1'b0, seen[1]);
        ctl.cyc(1'b1, 1'b1, seen[2]);
        chk("bypass path", 32'(seen[2:0]), 32'h2);
        repeat (5) ctl.cyc(1'b1, 1'b0, b);
        ctl.pin(1'b1, 1'b0);
        repeat (20) @(posedge pclk);
        chk("stopped clock", 32'(tap_in_reset), 32'h0);
        trst(1'b1, 1'b0);
        chk("clocked reset", 32'(tap_in_reset), 32'h1);
        report_and_stop();
    end
endmodule
